// *** hdl/udc_pkg.sv ***
// Constants, register map and carrier types for the up/down counter.
// Assumes a single 100 MHz bus clock and an AHB-Lite master.
package udc_pkg;

  // ==========================================================
  // Register map
  localparam logic [31:0] UDC_CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] UDC_STAT_OFS = 32'h0000_0004;

  // ==========================================================
  // Field positions and reset values
  localparam int UDC_LOAD_N_BIT = 0;
  localparam int UDC_CEP_N_BIT = 1;
  localparam int UDC_DIR_UP_BIT = 2;
  localparam int UDC_SYNC_CLEAR_N_N_BIT = 3;
  localparam int UDC_OFF_BIT = 4;
  localparam int UDC_PRESET_LSB = 5;
  localparam int UDC_CTRL_W = 9;
  localparam int UDC_STAT_W = 7;
  localparam logic [8:0] UDC_CTRL_RST = 9'h01f;
  localparam logic [3:0] UDC_CNT_MAX = 4'hf;
  localparam logic [3:0] UDC_CNT_ZERO = 4'h0;
  localparam logic [1:0] UDC_HTRANS_NONSEQ = 2'h2;
  localparam logic UDC_HRESP_OKAY = 1'b0;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic [3:0] preset;
    logic output_off;
    logic sync_clear_n;
    logic dir_up;
    logic count_enable_parallel_n;
    logic load_n;
  } udc_ctrl_t;

  typedef struct packed {
    logic counting;
    logic count_enable_trickle_n;
    logic ripple_carry_flag_n;
    logic [3:0] count;
  } udc_stat_t;

endpackage

// *** hdl/udc_ahb_regs.sv ***
// AHB-Lite register slave holding the counter control word.
// Assumes a zero-wait master and one slave on the bus.
`timescale 1ns/1ps
module udc_ahb_regs
  import udc_pkg::*;
(
  // Clock, reset and enable
  input logic hclk,
  input logic hresetn,
  input logic clk_en,
  // AHB-Lite slave
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Counter side
  output udc_ctrl_t ctrl,
  input udc_stat_t stat
);

  // ==========================================================
  // Address phase decode
  logic dp_valid_reg;
  logic dp_write_reg;
  logic dp_ctrl_reg;
  logic [31:0] hrdata_reg;
  udc_ctrl_t ctrl_reg;

  wire addr_take = hsel & htrans[1] & hready & clk_en;
  wire sel_ctrl = (haddr[31:2] == UDC_CTRL_OFS[31:2]);
  wire sel_stat = (haddr[31:2] == UDC_STAT_OFS[31:2]);
  wire [31:0] rd_mux = sel_ctrl ? {23'h0, ctrl_reg} :
                       sel_stat ? {25'h0, stat} : 32'h0;
  wire wr_ctrl = clk_en & dp_valid_reg & dp_write_reg & dp_ctrl_reg;

  // Transfer size is not checked; only whole words are expected.
  wire unused_size = |hsize;

  // ==========================================================
  // Data phase and registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_ctrl_reg <= 1'b0;
    end else if (clk_en) begin
      dp_valid_reg <= addr_take;
      dp_write_reg <= hwrite & ~unused_size | hwrite;
      dp_ctrl_reg <= sel_ctrl;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0;
    end else if (addr_take && !hwrite) begin
      hrdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= udc_ctrl_t'(UDC_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_reg <= udc_ctrl_t'(hwdata[UDC_CTRL_W-1:0]);
    end
  end

  // A pending data phase stalls while the clock enable is low.
  assign hreadyout = ~dp_valid_reg | clk_en;
  assign hresp = UDC_HRESP_OKAY;
  assign hrdata = hrdata_reg;
  assign ctrl = ctrl_reg;

endmodule

// *** hdl/udc_counter_top.sv ***
// Four-bit up/down counter with cascade carries and three-state
// count outputs, controlled from an AHB-Lite register slave.
// Assumes inputs synchronous to hclk; master clear may be async.
`timescale 1ns/1ps
module udc_counter_top
  import udc_pkg::*;
#(
  parameter int WIDTH = 4
)
(
  // Clock, reset and enable
  input logic hclk,
  input logic hresetn,
  input logic clk_en,
  // AHB-Lite slave
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Clear and cascade pins
  input logic master_clear_n,
  input logic count_enable_trickle_n,
  output logic ripple_carry_flag_n,
  output logic clocked_carry_pulse_n,
  // Three-state count outputs
  output logic count_q0,
  output logic count_q1,
  output logic count_q2,
  output logic count_q3,
  output logic count_q_oe
);

  // ==========================================================
  // Helper functions
  function automatic logic [3:0] udc_step(input logic [3:0] c,
                                          input logic up);
    udc_step = up ? 4'(c + 4'h1) : 4'(c - 4'h1);
  endfunction

  function automatic logic udc_terminal(input logic [3:0] c,
                                        input logic up);
    udc_terminal = up ? (c == UDC_CNT_MAX) : (c == UDC_CNT_ZERO);
  endfunction

  // ==========================================================
  // Register slave
  udc_ctrl_t ctrl;
  udc_stat_t stat;
  logic [3:0] count_reg;
  logic [3:0] count_next;

  udc_ahb_regs u_regs (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .ctrl(ctrl),
    .stat(stat)
  );

  // ==========================================================
  // Control decode
  wire load_n = ctrl.load_n;
  wire cep_n = ctrl.count_enable_parallel_n;
  wire dir_up = ctrl.dir_up;
  wire sync_clear_n_n = ctrl.sync_clear_n;
  wire cet_n = count_enable_trickle_n;
  // Counting needs load high and both enables low.
  wire counting = load_n & ~cep_n & ~cet_n;
  wire [3:0] stepped = udc_step(count_reg, dir_up);
  wire at_terminal = udc_terminal(count_reg, dir_up);
  // Look-ahead carry: no flip-flop between count and flag.
  wire carry_flag_n = ~(at_terminal & ~cet_n);
  wire arst_n = hresetn & master_clear_n;

  // ==========================================================
  // Next count, in priority order
  always_comb begin
    if (!sync_clear_n_n) begin
      count_next = UDC_CNT_ZERO;
    end else if (!load_n) begin
      count_next = ctrl.preset;
    end else if (counting) begin
      count_next = stepped;
    end else begin
      count_next = count_reg;
    end
  end

  // ==========================================================
  // Count register
  always_ff @(posedge hclk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= UDC_CNT_ZERO;
    end else if (clk_en) begin
      count_reg <= count_next;
    end
  end

  // ==========================================================
  // Cascade outputs
  assign ripple_carry_flag_n = carry_flag_n;
  // Low only in the low phase of the clock while counting at the
  // terminal count; the parallel enable keeps it high.
  assign clocked_carry_pulse_n =
    ~(clk_en & counting & ~carry_flag_n & ~hclk);

  // ==========================================================
  // Three-state count outputs
  assign count_q0 = count_reg[0];
  assign count_q1 = count_reg[1];
  assign count_q2 = count_reg[2];
  assign count_q3 = count_reg[3];
  assign count_q_oe = ~ctrl.output_off;

  // ==========================================================
  // Status word
  assign stat = {counting, cet_n, carry_flag_n, count_reg};

  // ==========================================================
  // Assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!arst_n);

  AST_FREEZE: assert property (
    !clk_en |=> $stable(count_reg)
  ) else $error("count moved while clock enable low");

  AST_LOAD: assert property (
    clk_en && sync_clear_n_n && !load_n |=> count_reg == $past(ctrl.preset)
  ) else $error("parallel load did not take preset");

  AST_INHIBIT: assert property (
    clk_en && sync_clear_n_n && load_n && (cep_n || cet_n)
      |=> $stable(count_reg)
  ) else $error("count changed while inhibited");

  AST_UP: assert property (
    clk_en && sync_clear_n_n && counting && dir_up
      |=> count_reg == 4'($past(count_reg) + 4'h1)
  ) else $error("up count wrong");

  AST_DOWN: assert property (
    clk_en && sync_clear_n_n && counting && !dir_up
      |=> count_reg == 4'($past(count_reg) - 4'h1)
  ) else $error("down count wrong");

  AST_FLAG_DECODE: assert property (
    ripple_carry_flag_n == !(!cet_n && (dir_up ?
      count_reg == 4'hf : count_reg == 4'h0))
  ) else $error("carry flag decode wrong");

  AST_TRICKLE_GATE: assert property (
    cet_n |-> ripple_carry_flag_n && clocked_carry_pulse_n
  ) else $error("trickle enable did not gate carry");

  AST_LOOKAHEAD: assert property (
    $changed(dir_up) && !cet_n && count_reg == 4'h0 && !dir_up
      |-> !ripple_carry_flag_n
  ) else $error("carry flag lagged direction change");

  AST_CCO_PHASE: assert property (
    clocked_carry_pulse_n ==
      !(clk_en && counting && !ripple_carry_flag_n)
  ) else $error("clocked carry wrong in low phase");

  AST_CCO_HIGH: assert property (
    @(negedge hclk) disable iff (!arst_n)
    clocked_carry_pulse_n
  ) else $error("clocked carry low in high phase");

  AST_CEP_FLAG: assert property (
    cep_n && !cet_n && dir_up && count_reg == 4'hf
      |-> !ripple_carry_flag_n
  ) else $error("parallel enable affected carry flag");

  AST_MASTER_CLEAR: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !master_clear_n |-> count_reg == 4'h0
  ) else $error("master clear did not zero count");

  AST_SYNC_CLEAR: assert property (
    clk_en && !sync_clear_n_n |=> count_reg == 4'h0
  ) else $error("sync clear did not zero count");

  AST_OUTPUTS: assert property (
    count_q_oe == !ctrl.output_off &&
    {count_q3, count_q2, count_q1, count_q0} == count_reg
  ) else $error("count outputs wrong");

  AST_WRAP_UP: assert property (
    clk_en && sync_clear_n_n && counting && dir_up && count_reg == 4'hf
      |=> count_reg == 4'h0
  ) else $error("up wrap wrong");

  AST_WRAP_DOWN: assert property (
    clk_en && sync_clear_n_n && counting && !dir_up && count_reg == 4'h0
      |=> count_reg == 4'hf
  ) else $error("down wrap wrong");

  AST_CCO_CEP: assert property (
    cep_n |-> clocked_carry_pulse_n
  ) else $error("clocked carry low while parallel enable high");

  AST_PRIORITY: assert property (
    clk_en && !sync_clear_n_n && !load_n |=> count_reg == 4'h0
  ) else $error("load beat sync clear");

  // ==========================================================
  // Coverage
  COV_OVERFLOW: cover property (
    counting && dir_up && !ripple_carry_flag_n ##1 count_reg == 4'h0
  );
  COV_UNDERFLOW: cover property (
    counting && !dir_up && !ripple_carry_flag_n ##1 count_reg == 4'hf
  );
  COV_LOAD: cover property (
    clk_en && sync_clear_n_n && !load_n ##1 count_reg != 4'h0
  );
  COV_FLOAT: cover property (
    !count_q_oe && counting
  );
  COV_CCO_PULSE: cover property (
    !clocked_carry_pulse_n
  );

endmodule

// *** sim/udc_stage_model.sv ***
// Behavioural earlier cascade stage that feeds the trickle enable.
// Assumes its controls change by non-blocking assignment after hclk.
`timescale 1ns/1ps
module udc_stage_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Stage controls
  input wire logic stage_cet_n,
  input wire logic stage_cep_n,
  input wire logic stage_load_f,
  // Carry towards the next stage
  output logic stage_flag_n
);
  logic [3:0] stage_cnt_reg;
  // Flag low at all ones only while its own trickle enable is low.
  assign stage_flag_n = stage_cet_n | (stage_cnt_reg != 4'hf);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage_cnt_reg <= 4'h0;
    end else if (stage_load_f) begin
      stage_cnt_reg <= 4'hf;
    end else if (!stage_cet_n && !stage_cep_n) begin
      stage_cnt_reg <= stage_cnt_reg + 4'h1;
    end
  end
endmodule

// *** sim/udc_counter_top_tb.sv ***
// Self-checking bench for the up/down counter behind AHB-Lite.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module udc_counter_top_tb;
  import udc_pkg::*;
  logic hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r, w;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic master_clear_n, cet_n, flag_n, cco_n, oe, e_fl;
  logic q0, q1, q2, q3, s_cet_n, s_cep_n, s_load_f;
  logic [3:0] exp_cnt, bus_q, bus_last;
  logic [6:0] snap;
  udc_ctrl_t exp_ctrl;
  int n_errors, checked, i;
  // ============================================================
  // Design and far side
  udc_counter_top #(.WIDTH(4)) udc_counter_top_inst (.hclk(hclk),
    .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .master_clear_n(master_clear_n),
    .count_enable_trickle_n(cet_n), .ripple_carry_flag_n(flag_n),
    .clocked_carry_pulse_n(cco_n), .count_q0(q0), .count_q1(q1),
    .count_q2(q2), .count_q3(q3), .count_q_oe(oe));
  udc_stage_model udc_stage_model_inst (.hclk(hclk), .hresetn(hresetn),
    .stage_cet_n(s_cet_n), .stage_cep_n(s_cep_n),
    .stage_load_f(s_load_f), .stage_flag_n(cet_n));
  // Released count pins show the inverse of their last driven value.
  assign bus_q = oe ? {q3, q2, q1, q0} : ~bus_last;
  always @(posedge hclk) if (oe === 1'b1) bus_last <= {q3, q2, q1, q0};
  // ============================================================
  // Expectations
  function automatic logic e_flag(logic [3:0] c, udc_ctrl_t k, logic t);
    return t | (k.dir_up ? c != UDC_CNT_MAX : c != UDC_CNT_ZERO);
  endfunction
  function automatic logic e_run(udc_ctrl_t k, logic t);
    return k.load_n & ~k.count_enable_parallel_n & ~t;
  endfunction
  function automatic logic [3:0] e_next(logic [3:0] c, udc_ctrl_t k,
                                        logic t);
    if (!k.sync_clear_n) return 4'h0;
    if (!k.load_n) return k.preset;
    if (!e_run(k, t)) return c;
    return k.dir_up ? c + 4'h1 : c - 4'h1;
  endfunction
  always @(posedge hclk or negedge hresetn or negedge master_clear_n)
    if (!hresetn || !master_clear_n) exp_cnt <= 4'h0;
    else if (clk_en) exp_cnt <= e_next(exp_cnt, exp_ctrl, cet_n);
  // ============================================================
  // Checking
  task automatic check(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  always @(negedge hclk) if (hresetn) begin
    #1;
    if (!exp_ctrl.output_off)
      check("count", bus_q, exp_cnt);
    check("oe", oe, !exp_ctrl.output_off);
    e_fl = e_flag(exp_cnt, exp_ctrl, cet_n);
    check("flag", flag_n, e_fl);
    check("cco_low", cco_n, !(clk_en & e_run(exp_ctrl, cet_n) & !e_fl));
  end
  always @(posedge hclk) if (hresetn) #2 check("cco_high", cco_n, 1'b1);
  task automatic ahb(input logic wr, input logic [31:0] a, d);
    hsel <= 1'b1;
    hsize <= 3'h2;
    haddr <= a;
    htrans <= UDC_HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    snap = {e_run(exp_ctrl, cet_n), cet_n,
            e_flag(exp_cnt, exp_ctrl, cet_n), exp_cnt};
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    check("hresp", hresp, UDC_HRESP_OKAY);
    if (wr && a == UDC_CTRL_OFS) exp_ctrl <= udc_ctrl_t'(d[8:0]);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    hclk = 0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    end_of_test;
  end
  // ============================================================
  // Main sequence
  initial begin
    {hsel, hwrite, haddr, hwdata, htrans, s_cet_n, s_cep_n} = '0;
    {hresetn, hsize, bus_last, n_errors, checked} = '0;
    {clk_en, master_clear_n, s_load_f} = 3'h7;
    exp_ctrl = udc_ctrl_t'(UDC_CTRL_RST);
    i = $urandom(69375);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, UDC_CTRL_OFS, 0);
    check("ctrl_reset", r, {23'h0, UDC_CTRL_RST});
    ahb(1, 32'h8, 32'hffff_ffff);
    ahb(0, 32'h8, 0);
    check("unmapped", r, 32'h0);
    ahb(1, UDC_STAT_OFS, 32'h7f);
    ahb(0, UDC_STAT_OFS, 0);
    check("stat", r, {25'h0, snap});
    $display("test registers done");
    s_load_f <= 1'b1;
    s_cep_n <= 1'b1;
    foreach (w[k]) if (k < 2) begin
      ahb(1, UDC_CTRL_OFS, 32'h1ce);
      ahb(1, UDC_CTRL_OFS, k ? 32'h1c9 : 32'h1cd);
      repeat (20) @(posedge hclk);
    end
    ahb(1, UDC_CTRL_OFS, 32'h00f);
    master_clear_n <= 1'b0;
    #1 check("mclr", bus_q, 4'h0);
    @(posedge hclk);
    master_clear_n <= 1'b1;
    $display("test corners done");
    for (i = 0; i < 150; i++) begin
      w = $urandom;
      w[0] = ($urandom % 4) != 0;
      w[3] = ($urandom % 6) != 0;
      ahb(1, UDC_CTRL_OFS, w);
      s_cep_n <= 1'($urandom);
      s_cet_n <= ($urandom % 4) == 0;
      s_load_f <= ($urandom % 8) == 0;
      @(posedge hclk);
      s_load_f <= 1'b0;
      repeat ($urandom_range(1, 12)) begin
        clk_en <= ($urandom % 5) != 0;
        @(posedge hclk);
      end
      clk_en <= 1'b1;
      ahb(0, UDC_STAT_OFS, 0);
      check("stat", r, {25'h0, snap});
      ahb(0, UDC_CTRL_OFS, 0);
      check("ctrl", r, {23'h0, w[8:0]});
    end
    $display("test random done");
    end_of_test;
  end
endmodule
